// File: hdl/dobsrv_pin_mux.sv
// module: observation pin multiplexer
`timescale 1ns/1ps
module dobsrv_pin_mux (
  input wire logic [9:0] sel,
  input wire logic div_clk,
  input wire logic [15:0] recv_a,
  input wire logic [15:0] recv_b,
  input wire logic interrupt_out,
  output logic pin_value
);
  always_comb begin
    pin_value = 1'b0; // unlisted codes idle low
    if (sel == dobsrv_pkg::SEL_DIVCLK) begin
      pin_value = div_clk;
    end else if (sel[9:4] == dobsrv_pkg::SEL_BBIT_HI) begin
      pin_value = recv_b[sel[3:0]];
    end else begin
      unique case (sel)
        dobsrv_pkg::SEL_AND_B: pin_value = &recv_b;
        dobsrv_pkg::SEL_OR_B: pin_value = |recv_b;
        dobsrv_pkg::SEL_AND_A: pin_value = &recv_a;
        dobsrv_pkg::SEL_OR_A: pin_value = |recv_a;
        dobsrv_pkg::SEL_INT_LOW: pin_value = ~interrupt_out;
        dobsrv_pkg::SEL_INT_HIGH: pin_value = interrupt_out;
        dobsrv_pkg::SEL_CONST_LO: pin_value = 1'b0;
        dobsrv_pkg::SEL_CONST_HI: pin_value = 1'b1;
        default: pin_value = 1'b0;
      endcase
    end
  end
endmodule

// File: hdl/dobsrv_pkg.sv
// package: register map, selector codes and identity defaults
package dobsrv_pkg;
  // ==========================================================
  // register offsets
  localparam logic [4:0] OFS_OBSERVE_SEL = 5'h11;
  localparam logic [4:0] OFS_TYPE_DESC = 5'h1B;
  localparam logic [4:0] OFS_CORE_VER = 5'h1C;
  localparam logic [4:0] OFS_LOGIC_VER = 5'h1D;
  localparam logic [4:0] OFS_RECV_VER = 5'h1E;
  localparam logic [4:0] OFS_PAGE_SEL = 5'h1F;
  // ==========================================================
  // reset values and widths
  localparam logic [9:0] OBSERVE_SEL_RST = 10'h000;
  localparam logic [2:0] PAGE_SEL_RST = 3'h0;
  localparam int SEL_W = 10;
  localparam int PAGE_W = 3;
  // ==========================================================
  // selector codes
  localparam logic [9:0] SEL_DIVCLK = 10'h000;
  localparam logic [5:0] SEL_BBIT_HI = 6'h10;
  localparam logic [9:0] SEL_AND_B = 10'h20F;
  localparam logic [9:0] SEL_OR_B = 10'h21F;
  localparam logic [9:0] SEL_AND_A = 10'h22F;
  localparam logic [9:0] SEL_OR_A = 10'h23F;
  localparam logic [9:0] SEL_INT_LOW = 10'h3C0;
  localparam logic [9:0] SEL_INT_HIGH = 10'h3C1;
  localparam logic [9:0] SEL_CONST_LO = 10'h3FE;
  localparam logic [9:0] SEL_CONST_HI = 10'h3FF;
  // ==========================================================
  // type descriptor fields
  localparam int TYPE_DSP_LSB = 2;
  localparam logic [1:0] DSP_FILT_AND_MOD = 2'h3;
  localparam logic [1:0] DSP_MOD_ONLY = 2'h2;
  localparam logic [1:0] DSP_FILT_ONLY = 2'h1;
  localparam logic [1:0] DSP_NONE = 2'h0;
  localparam logic [1:0] FRONTEND_RECV = 2'h1;
  // divided clock ratio to sample clock
  localparam int DIVCLK_RATIO = 8;
  localparam logic [1:0] DIV_HALF_TERM = 2'h3;
endpackage

// File: hdl/dobsrv_regs.sv
// module: observe mux and identity register bank
`timescale 1ns/1ps
module dobsrv_regs #(
  parameter logic [1:0] DSP_PRESENT = dobsrv_pkg::DSP_FILT_AND_MOD,
  parameter logic CALIBRATED = 1'b0,
  // version numbers: arbitrary values
  parameter logic [7:0] CORE_VERSION = 8'h01,
  parameter logic [7:0] LOGIC_VERSION = 8'h01,
  parameter logic [7:0] RECV_VERSION = 8'h01
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [15:0] recv_a,
  input wire logic [15:0] recv_b,
  input wire logic interrupt_out,
  output logic observe_pin,
  output logic [2:0] page
);
  // ==========================================================
  // reset synchroniser
  logic rst_s1_ff;
  logic rst_s2_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff <= 1'b0;
      rst_s2_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_s2_ff <= rst_s1_ff;
    end
  end
  wire logic srst_n = rst_s2_ff;

  // ==========================================================
  // registers: the ten-bit selector does not fit one byte, so
  // page 0 holds bits 7:0 and any other page bits 9:8 at the
  // same offset; the pin may show a mixed code between the two
  // writes, which software should expect
  logic [9:0] sel_ff;
  logic [9:0] nxt_sel;
  logic [2:0] page_ff;
  logic [2:0] nxt_page;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic [7:0] type_desc;
  logic [1:0] div_ff;
  logic [1:0] nxt_div;
  logic div_clk_ff;
  logic nxt_div_clk;
  logic pin_comb;
  logic pin_ff;

  assign type_desc = {CALIBRATED, dobsrv_pkg::FRONTEND_RECV, 1'b0,
                      DSP_PRESENT, 2'h0};

  always_comb begin
    nxt_sel = sel_ff;
    nxt_page = page_ff;
    nxt_rdata = rdata_ff;
    // the selector is ten bits wide: page 0 holds bits 7:0,
    // page 1 at the same offset holds bits 9:8
    if (reg_wr && reg_addr == dobsrv_pkg::OFS_OBSERVE_SEL) begin
      if (page_ff == 3'h0) begin
        nxt_sel[7:0] = reg_wdata;
      end else begin
        nxt_sel[9:8] = reg_wdata[1:0];
      end
    end
    if (reg_wr && reg_addr == dobsrv_pkg::OFS_PAGE_SEL) begin
      nxt_page = reg_wdata[2:0];
    end
    // version offsets ignore writes entirely
    if (reg_rd) begin
      unique case (reg_addr)
        dobsrv_pkg::OFS_OBSERVE_SEL:
          nxt_rdata = (page_ff == 3'h0) ? sel_ff[7:0]
                                        : {6'h00, sel_ff[9:8]};
        dobsrv_pkg::OFS_TYPE_DESC: nxt_rdata = type_desc;
        dobsrv_pkg::OFS_CORE_VER: nxt_rdata = CORE_VERSION;
        dobsrv_pkg::OFS_LOGIC_VER: nxt_rdata = LOGIC_VERSION;
        dobsrv_pkg::OFS_RECV_VER: nxt_rdata = RECV_VERSION;
        dobsrv_pkg::OFS_PAGE_SEL: nxt_rdata = {5'h00, page_ff};
        default: nxt_rdata = 8'h00;
      endcase
    end
  end

  // divide by eight: toggle every fourth clock, clk is the sample clock
  always_comb begin
    nxt_div = div_ff + 2'h1;
    nxt_div_clk = div_clk_ff;
    if (div_ff == dobsrv_pkg::DIV_HALF_TERM) begin
      nxt_div_clk = ~div_clk_ff;
    end
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      sel_ff <= dobsrv_pkg::OBSERVE_SEL_RST;
      page_ff <= dobsrv_pkg::PAGE_SEL_RST;
      rdata_ff <= 8'h00;
      div_ff <= 2'h0;
      div_clk_ff <= 1'b0;
      pin_ff <= 1'b0;
    end else begin
      sel_ff <= nxt_sel;
      page_ff <= nxt_page;
      rdata_ff <= nxt_rdata;
      div_ff <= nxt_div;
      div_clk_ff <= nxt_div_clk;
      pin_ff <= pin_comb;
    end
  end

  // ==========================================================
  // pin mux
  dobsrv_pin_mux i_dobsrv_pin_mux (
    .sel(sel_ff),
    .div_clk(div_clk_ff),
    .recv_a(recv_a),
    .recv_b(recv_b),
    .interrupt_out(interrupt_out),
    .pin_value(pin_comb)
  );

  assign observe_pin = pin_ff;
  assign reg_rdata = rdata_ff;
  assign page = page_ff;

  // ==========================================================
  // checks: the pin shows what the mux saw one edge earlier
  chk_divclk_route: assert property (
    @(posedge clk) disable iff (!srst_n)
    $past(sel_ff) == dobsrv_pkg::SEL_DIVCLK |->
    observe_pin == $past(div_clk_ff))
    else $error("divided clock not on pin");
  chk_divclk_period: assert property (
    @(posedge clk) disable iff (!srst_n)
    $rose(div_clk_ff) |-> div_clk_ff [*4] ##1 !div_clk_ff)
    else $error("divided clock period wrong");
  chk_bbit_route: assert property (
    @(posedge clk) disable iff (!srst_n)
    $past(sel_ff[9:4]) == dobsrv_pkg::SEL_BBIT_HI |->
    observe_pin == $past(recv_b[sel_ff[3:0]]))
    else $error("channel B bit not routed");
  chk_b_reduce: assert property (
    @(posedge clk) disable iff (!srst_n)
    $past(sel_ff) == dobsrv_pkg::SEL_AND_B |->
    observe_pin == $past(&recv_b))
    else $error("channel B AND wrong");
  chk_b_or: assert property (
    @(posedge clk) disable iff (!srst_n)
    $past(sel_ff) == dobsrv_pkg::SEL_OR_B |->
    observe_pin == $past(|recv_b))
    else $error("channel B OR wrong");
  chk_a_and: assert property (
    @(posedge clk) disable iff (!srst_n)
    $past(sel_ff) == dobsrv_pkg::SEL_AND_A |->
    observe_pin == $past(&recv_a))
    else $error("channel A AND wrong");
  chk_a_reduce: assert property (
    @(posedge clk) disable iff (!srst_n)
    $past(sel_ff) == dobsrv_pkg::SEL_OR_A |->
    observe_pin == $past(|recv_a))
    else $error("channel A OR wrong");
  chk_int_low: assert property (
    @(posedge clk) disable iff (!srst_n)
    $past(sel_ff) == dobsrv_pkg::SEL_INT_LOW |->
    observe_pin == !$past(interrupt_out))
    else $error("inverted interrupt wrong");
  chk_int_high: assert property (
    @(posedge clk) disable iff (!srst_n)
    $past(sel_ff) == dobsrv_pkg::SEL_INT_HIGH |->
    observe_pin == $past(interrupt_out))
    else $error("direct interrupt wrong");
  chk_const_lo: assert property (
    @(posedge clk) disable iff (!srst_n)
    $past(sel_ff) == dobsrv_pkg::SEL_CONST_LO |-> !observe_pin)
    else $error("constant low wrong");
  chk_const_hi: assert property (
    @(posedge clk) disable iff (!srst_n)
    $past(sel_ff) == dobsrv_pkg::SEL_CONST_HI |-> observe_pin)
    else $error("constant high wrong");
  chk_type_read: assert property (
    @(posedge clk) disable iff (!srst_n)
    reg_rd && reg_addr == dobsrv_pkg::OFS_TYPE_DESC |=>
    reg_rdata[dobsrv_pkg::TYPE_DSP_LSB +: 2] == DSP_PRESENT)
    else $error("processing field wrong");
  chk_core_ver: assert property (
    @(posedge clk) disable iff (!srst_n)
    reg_rd && reg_addr == dobsrv_pkg::OFS_CORE_VER |=>
    reg_rdata == CORE_VERSION)
    else $error("core version read wrong");
  chk_logic_ver: assert property (
    @(posedge clk) disable iff (!srst_n)
    reg_rd && reg_addr == dobsrv_pkg::OFS_LOGIC_VER |=>
    reg_rdata == LOGIC_VERSION)
    else $error("logic version read wrong");
  chk_recv_ver: assert property (
    @(posedge clk) disable iff (!srst_n)
    reg_rd && reg_addr == dobsrv_pkg::OFS_RECV_VER |=>
    reg_rdata == RECV_VERSION)
    else $error("receiver version read wrong");
  chk_page_write: assert property (
    @(posedge clk) disable iff (!srst_n)
    reg_wr && reg_addr == dobsrv_pkg::OFS_PAGE_SEL |=>
    page == $past(reg_wdata[2:0]))
    else $error("page write lost");
  chk_page_back: assert property (
    @(posedge clk) disable iff (!srst_n)
    reg_wr && reg_addr == dobsrv_pkg::OFS_PAGE_SEL ##1 !reg_wr ##1
    reg_rd && reg_addr == dobsrv_pkg::OFS_PAGE_SEL |=>
    reg_rdata == {5'h00, $past(reg_wdata[2:0], 3)})
    else $error("page readback wrong");
  chk_unlisted: assert property (
    @(posedge clk) disable iff (!srst_n)
    $past(sel_ff) == 10'h155 |-> !observe_pin)
    else $error("unlisted code not low");
  cov_divclk: cover property (@(posedge clk) $rose(div_clk_ff));
  cov_bbit: cover property (@(posedge clk) sel_ff[9:4] == 6'h10);
  cov_int_high: cover property (@(posedge clk) sel_ff == 10'h3C1);
  cov_page_wr: cover property (@(posedge clk)
    reg_wr && reg_addr == 5'h1F);
  cov_unlisted: cover property (@(posedge clk) sel_ff == 10'h155);
endmodule

// File: verification/debug_observe_mux_and_id_regs_bench.sv
// bench: observe mux and identity register bank against a reference model
`timescale 1ns/1ps
module debug_observe_mux_and_id_regs_bench;
  logic clk, rst_n, reg_wr, reg_rd, interrupt_out, observe_pin;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, k;
  logic [15:0] recv_a, recv_b;
  logic [2:0] page;
  logic [9:0] code;
  logic [31:0] seed, r, t;
  int err_count, checks, ones, flips;
  logic prev, exp_bit;
  // 10'h155 is deliberately not a listed code
  localparam logic [9:0] CODES [9] = '{dobsrv_pkg::SEL_AND_B,
    dobsrv_pkg::SEL_OR_B, dobsrv_pkg::SEL_AND_A, dobsrv_pkg::SEL_OR_A,
    dobsrv_pkg::SEL_INT_LOW, dobsrv_pkg::SEL_INT_HIGH,
    dobsrv_pkg::SEL_CONST_LO, dobsrv_pkg::SEL_CONST_HI, 10'h155};

  dobsrv_regs #(.CORE_VERSION(8'hA5), .LOGIC_VERSION(8'h3C),
    .RECV_VERSION(8'h96)) i_dobsrv_regs (.clk(clk), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .recv_a(recv_a),
    .recv_b(recv_b), .interrupt_out(interrupt_out),
    .observe_pin(observe_pin), .page(page));

  // ==========================================================
  // model and helpers
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic exp_pin(logic [9:0] s, logic [15:0] a,
                                   logic [15:0] b, logic it);
    if (s[9:4] == dobsrv_pkg::SEL_BBIT_HI) return b[s[3:0]];
    case (s)
      dobsrv_pkg::SEL_AND_B: return &b;
      dobsrv_pkg::SEL_OR_B: return |b;
      dobsrv_pkg::SEL_AND_A: return &a;
      dobsrv_pkg::SEL_OR_A: return |a;
      dobsrv_pkg::SEL_INT_LOW: return ~it;
      dobsrv_pkg::SEL_INT_HIGH: return it;
      dobsrv_pkg::SEL_CONST_HI: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // a spare cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    reg_rd = 1'b1;
    reg_addr = a;
    tick(1);
    reg_rd = 1'b0;
    tick(1);
    chk(reg_rdata, exp);
  endtask

  task automatic set_sel(input logic [9:0] s);
    wr(dobsrv_pkg::OFS_PAGE_SEL, 8'h00);
    wr(dobsrv_pkg::OFS_OBSERVE_SEL, s[7:0]);
    wr(dobsrv_pkg::OFS_PAGE_SEL, 8'h01);
    wr(dobsrv_pkg::OFS_OBSERVE_SEL, {6'h00, s[9:8]});
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end

  // ==========================================================
  // main sequence
  initial begin
    seed = 32'hEEE1D86A;
    {rst_n, reg_wr, reg_rd, interrupt_out} = 4'h0;
    {reg_addr, reg_wdata, recv_a, recv_b} = '0;
    err_count = 0;
    checks = 0;
    ones = 0;
    flips = 0;
    tick(4);
    rst_n = 1'b1;
    tick(4);
    prev = observe_pin;
    repeat (16) begin
      tick(1);
      ones += int'(observe_pin === 1'b1);
      flips += int'(observe_pin !== prev);
      prev = observe_pin;
    end
    // half high and four edges in two periods of eight cycles
    chk(8'(ones), 8'h08);
    chk(8'(flips), 8'h04);
    chk({5'h00, page}, 8'h00);
    rd(dobsrv_pkg::OFS_OBSERVE_SEL, 8'h00);
    rd(dobsrv_pkg::OFS_TYPE_DESC, 8'h2C);
    rd(dobsrv_pkg::OFS_CORE_VER, 8'hA5);
    wr(dobsrv_pkg::OFS_CORE_VER, 8'h5A);
    rd(dobsrv_pkg::OFS_CORE_VER, 8'hA5);
    rd(dobsrv_pkg::OFS_LOGIC_VER, 8'h3C);
    rd(dobsrv_pkg::OFS_RECV_VER, 8'h96);
    wr(dobsrv_pkg::OFS_PAGE_SEL, 8'h05);
    rd(dobsrv_pkg::OFS_PAGE_SEL, 8'h05);
    chk({5'h00, page}, 8'h05);
    for (int i = 0; i < 60; i++) begin
      r = xs();
      t = xs();
      k = r[15:8] % 8'h19;
      code = (k < 8'h10) ? {6'h10, k[3:0]} : CODES[k - 8'h10];
      set_sel(code);
      // all-ones and all-zero words make the reductions flip
      recv_a = r[0] ? 16'hFFFF : (r[1] ? 16'h0000 : t[15:0]);
      recv_b = r[2] ? 16'hFFFF : (r[3] ? 16'h0000 : t[31:16]);
      interrupt_out = r[4];
      tick(2);
      exp_bit = exp_pin(code, recv_a, recv_b, interrupt_out);
      chk(8'(observe_pin), 8'(exp_bit));
      rd(dobsrv_pkg::OFS_OBSERVE_SEL, {6'h00, code[9:8]});
    end
    // mid-run reset: page and selector fall back to reset values
    rst_n = 1'b0;
    tick(2);
    chk({5'h00, page}, {5'h00, dobsrv_pkg::PAGE_SEL_RST});
    rst_n = 1'b1;
    tick(4);
    rd(dobsrv_pkg::OFS_OBSERVE_SEL, dobsrv_pkg::OBSERVE_SEL_RST[7:0]);
    tally_and_finish();
  end
endmodule
